// ### hw/scg_classifier.sv
// Combinational allow-list check of one fetched command against the restriction state
`timescale 1ns/1ps
`default_nettype none
module scg_classifier
    import scg_pkg::*;
(
    scg_cmd_if.cls             cmd,
    input  wire scg_state_type state_i,
    input  wire logic          mgmt_allow_i,
    input  wire logic [7:0]    fail_action_mask_i
);
    wire       restricted = (state_i != SCG_ST_IDLE);
    wire       failed     = (state_i == SCG_ST_FAILED);
    wire [7:0] op         = cmd.opcode;

    // Plain admin entries without extra restrictions
    wire plain_ok = (op == SCG_OP_ABORT) || (op == SCG_OP_ASYNC_EV) || (op == SCG_OP_CRT_CQ) ||
                    (op == SCG_OP_CRT_SQ) || (op == SCG_OP_DEL_CQ) || (op == SCG_OP_DEL_SQ) ||
                    (op == SCG_OP_GET_FEAT) || (op == SCG_OP_IDENTIFY) || (op == SCG_OP_KEEP_ALV) ||
                    (op == SCG_OP_SET_FEAT);
    wire log_ok   = (op == SCG_OP_GET_LOG) && scg_log_ok(cmd.log_id);
    wire mgmt_ok  = ((op == SCG_OP_MGMT_SND) || (op == SCG_OP_MGMT_RCV)) && mgmt_allow_i;
    wire vs_ok    = scg_is_vendor(op) && !cmd.vs_user_data;
    wire admin_ok = cmd.is_admin && (plain_ok || log_ok || mgmt_ok || vs_ok);
    // Fabrics capsules may sit on any queue and are not I/O commands
    wire fab_ok   = (op == SCG_OP_FABRICS) && scg_fabric_ok(cmd.fctype) &&
                    !(scg_is_vendor(cmd.fctype) && cmd.vs_user_data);
    wire san_ok   = failed && cmd.is_admin && (op == SCG_OP_SANITIZE) &&
                    fail_action_mask_i[cmd.san_action];

    // While restricted, I/O commands match no term and fall through to abort
    assign cmd.allow  = !restricted || admin_ok || fab_ok || san_ok;
    assign cmd.status = cmd.allow ? SCG_SC_SUCCESS : (failed ? SCG_SC_FAILED : SCG_SC_IN_PROG);
endmodule
`default_nettype wire

// ### hw/scg_cmd_if.sv
// Carrier between the gate and its command classifier
`timescale 1ns/1ps
`default_nettype none
interface scg_cmd_if;
    logic       is_admin;
    logic [7:0] opcode;
    logic [7:0] fctype;
    logic [7:0] log_id;
    logic [2:0] san_action;
    logic       vs_user_data;
    logic       allow;
    logic [7:0] status;

    modport gate (output is_admin, opcode, fctype, log_id, san_action, vs_user_data,
                  input allow, status);
    modport cls  (input is_admin, opcode, fctype, log_id, san_action, vs_user_data,
                  output allow, status);
endinterface
`default_nettype wire

// ### hw/scg_gate.sv
// Sanitize command gate: restriction state and admission stage for fetched commands
`timescale 1ns/1ps
`default_nettype none
module scg_gate
    import scg_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       srst_i,
    // Fetched command
    input  wire logic       cmd_valid_i,
    output logic            cmd_ready_o,
    input  wire logic       cmd_admin_i,
    input  wire logic [7:0] cmd_opcode_i,
    input  wire logic [7:0] cmd_fctype_i,
    input  wire logic [7:0] cmd_log_id_i,
    input  wire logic [2:0] cmd_san_action_i,
    input  wire logic       cmd_vs_user_data_i,
    // Dispatch toward execution
    output logic            out_valid_o,
    input  wire logic       out_ready_i,
    output logic            out_admin_o,
    output logic [7:0]      out_opcode_o,
    output logic            out_abort_o,
    output logic [7:0]      out_status_o,
    output logic            out_lba_zero_o,
    // Sanitize progress events
    input  wire logic       san_cmd_done_i,
    input  wire logic       san_cmd_ok_i,
    input  wire logic [2:0] san_cmd_action_i,
    input  wire logic       san_op_done_i,
    input  wire logic       san_op_ok_i,
    // Static configuration
    input  wire logic       mgmt_allow_i,
    input  wire logic [7:0] fail_action_mask_i,
    // Subsystem-wide state
    output logic            san_in_prog_o,
    output logic            san_failed_o
);
    scg_state_type state_q;
    scg_state_type state_d;

    logic       out_valid_q;
    logic       out_admin_q;
    logic [7:0] out_opcode_q;
    logic       out_abort_q;
    logic [7:0] out_status_q;
    logic       out_lba_zero_q;

    scg_cmd_if cls_if ();

    assign cls_if.is_admin     = cmd_admin_i;
    assign cls_if.opcode       = cmd_opcode_i;
    assign cls_if.fctype       = cmd_fctype_i;
    assign cls_if.log_id       = cmd_log_id_i;
    assign cls_if.san_action   = cmd_san_action_i;
    assign cls_if.vs_user_data = cmd_vs_user_data_i;

    scg_classifier u_cls (
        .cmd                (cls_if),
        .state_i            (state_q),
        .mgmt_allow_i       (mgmt_allow_i),
        .fail_action_mask_i (fail_action_mask_i)
    );

    wire cmd_fire   = cmd_valid_i && cmd_ready_o;
    wire restricted = (state_q != SCG_ST_IDLE);
    wire err_log    = cmd_admin_i && (cmd_opcode_i == SCG_OP_GET_LOG) && (cmd_log_id_i == SCG_LOG_ERROR);
    wire san_start  = san_cmd_done_i && san_cmd_ok_i && (san_cmd_action_i != SCG_ACT_EXIT_FAIL);
    wire san_exit   = san_cmd_done_i && san_cmd_ok_i && (san_cmd_action_i == SCG_ACT_EXIT_FAIL);

    assign cmd_ready_o = !out_valid_q || out_ready_i;

    // State transitions
    always_comb begin
        state_d = state_q;
        case (state_q)
            SCG_ST_IDLE: begin
                if (san_start) begin
                    state_d = SCG_ST_RUN;
                end
            end
            SCG_ST_RUN: begin
                if (san_op_done_i) begin
                    state_d = san_op_ok_i ? SCG_ST_IDLE : SCG_ST_FAILED;
                end
            end
            SCG_ST_FAILED: begin
                if (san_start) begin
                    state_d = SCG_ST_RUN;
                end else if (san_exit) begin
                    state_d = SCG_ST_IDLE;
                end
            end
            default: begin
                state_d = SCG_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_q <= SCG_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Admission stage: verdict captured once when the command is taken
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            out_valid_q <= 1'b0;
        end else if (cmd_ready_o) begin
            out_valid_q <= cmd_valid_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            out_admin_q    <= 1'b0;
            out_opcode_q   <= SCG_RST_BYTE;
            out_abort_q    <= 1'b0;
            out_status_q   <= SCG_SC_SUCCESS;
            out_lba_zero_q <= 1'b0;
        end else if (cmd_fire) begin
            out_admin_q    <= cmd_admin_i;
            out_opcode_q   <= cmd_opcode_i;
            out_abort_q    <= !cls_if.allow;
            out_status_q   <= cls_if.status;
            out_lba_zero_q <= restricted && err_log;
        end
    end

    assign out_valid_o    = out_valid_q;
    assign out_admin_o    = out_admin_q;
    assign out_opcode_o   = out_opcode_q;
    assign out_abort_o    = out_abort_q;
    assign out_status_o   = out_status_q;
    assign out_lba_zero_o = out_lba_zero_q;
    assign san_in_prog_o  = (state_q == SCG_ST_RUN);
    assign san_failed_o   = (state_q == SCG_ST_FAILED);

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    chk_idle_pass: assert property (
        cmd_fire && state_q == SCG_ST_IDLE |=> out_valid_q && !out_abort_q && out_status_q == SCG_SC_SUCCESS)
        else $error("command aborted outside restriction");
    chk_allow_list_run: assert property (
        cmd_fire && state_q == SCG_ST_RUN && cmd_admin_i && cmd_opcode_i == SCG_OP_IDENTIFY |=> !out_abort_q)
        else $error("allow-listed command aborted while sanitizing");
    chk_io_abort_run: assert property (
        cmd_fire && state_q == SCG_ST_RUN && !cmd_admin_i && cmd_opcode_i != SCG_OP_FABRICS
        |=> out_abort_q && out_status_q == SCG_SC_IN_PROG)
        else $error("I/O command not aborted while sanitizing");
    chk_san_run_abort: assert property (
        cmd_fire && state_q == SCG_ST_RUN && cmd_opcode_i == SCG_OP_SANITIZE
        |=> out_abort_q && out_status_q == SCG_SC_IN_PROG)
        else $error("sanitize admitted while sanitizing");
    chk_fail_hold: assert property (
        state_q == SCG_ST_FAILED && !san_cmd_done_i |=> state_q == SCG_ST_FAILED)
        else $error("failed state left without cause");
    chk_fail_san_ok: assert property (
        cmd_fire && state_q == SCG_ST_FAILED && cmd_admin_i && cmd_opcode_i == SCG_OP_SANITIZE
        && fail_action_mask_i[cmd_san_action_i] |=> !out_abort_q)
        else $error("permitted sanitize refused in failed state");
    chk_io_abort_fail: assert property (
        cmd_fire && state_q == SCG_ST_FAILED && !cmd_admin_i && cmd_opcode_i != SCG_OP_FABRICS
        |=> out_abort_q && out_status_q == SCG_SC_FAILED)
        else $error("I/O command not aborted in failed state");
    chk_fail_action_mask: assert property (
        cmd_fire && state_q == SCG_ST_FAILED && cmd_opcode_i == SCG_OP_SANITIZE
        && !fail_action_mask_i[cmd_san_action_i] |=> out_abort_q && out_status_q == SCG_SC_FAILED)
        else $error("forbidden sanitize action admitted");
    chk_log_reject: assert property (
        cmd_fire && restricted && cmd_opcode_i == SCG_OP_GET_LOG && !scg_log_ok(cmd_log_id_i)
        |=> out_abort_q)
        else $error("disallowed log page admitted");
    chk_lba_zero: assert property (
        cmd_fire |=> out_lba_zero_q == ($past(state_q) != SCG_ST_IDLE && $past(cmd_admin_i)
            && $past(cmd_opcode_i) == SCG_OP_GET_LOG && $past(cmd_log_id_i) == SCG_LOG_ERROR))
        else $error("error log address masking wrong");
    chk_mgmt_block: assert property (
        cmd_fire && restricted && cmd_opcode_i == SCG_OP_MGMT_SND && !mgmt_allow_i |=> out_abort_q)
        else $error("management command admitted");
    chk_fabric_sub: assert property (
        cmd_fire && restricted && cmd_opcode_i == SCG_OP_FABRICS && !scg_fabric_ok(cmd_fctype_i)
        |=> out_abort_q)
        else $error("fabrics subcommand admitted");
    chk_vendor_user: assert property (
        cmd_fire && restricted && scg_is_vendor(cmd_opcode_i) && cmd_vs_user_data_i |=> out_abort_q)
        else $error("vendor user-data command admitted");
    chk_fail_exit: assert property (
        state_q == SCG_ST_FAILED && san_exit |=> state_q == SCG_ST_IDLE)
        else $error("exit action did not leave failed state");
    chk_no_bad_start: assert property (
        state_q == SCG_ST_IDLE && !san_start |=> state_q == SCG_ST_IDLE)
        else $error("in-progress entered without successful sanitize");
endmodule
`default_nettype wire

// ### hw/scg_pkg.sv
// Shared constants, types and decode functions for the sanitize command gate
package scg_pkg;

    // Restriction state of the whole subsystem
    typedef enum logic [1:0] {
        SCG_ST_IDLE,
        SCG_ST_RUN,
        SCG_ST_FAILED
    } scg_state_type;

    // Completion status codes (generic status)
    localparam logic [7:0] SCG_SC_SUCCESS  = 8'h00;
    localparam logic [7:0] SCG_SC_FAILED   = 8'h1C;
    localparam logic [7:0] SCG_SC_IN_PROG  = 8'h1D;

    // Admin opcodes
    localparam logic [7:0] SCG_OP_DEL_SQ   = 8'h00;
    localparam logic [7:0] SCG_OP_CRT_SQ   = 8'h01;
    localparam logic [7:0] SCG_OP_GET_LOG  = 8'h02;
    localparam logic [7:0] SCG_OP_DEL_CQ   = 8'h04;
    localparam logic [7:0] SCG_OP_CRT_CQ   = 8'h05;
    localparam logic [7:0] SCG_OP_IDENTIFY = 8'h06;
    localparam logic [7:0] SCG_OP_ABORT    = 8'h08;
    localparam logic [7:0] SCG_OP_SET_FEAT = 8'h09;
    localparam logic [7:0] SCG_OP_GET_FEAT = 8'h0A;
    localparam logic [7:0] SCG_OP_ASYNC_EV = 8'h0C;
    localparam logic [7:0] SCG_OP_KEEP_ALV = 8'h18;
    localparam logic [7:0] SCG_OP_MGMT_SND = 8'h1D;
    localparam logic [7:0] SCG_OP_MGMT_RCV = 8'h1E;
    localparam logic [7:0] SCG_OP_FABRICS  = 8'h7F;
    localparam logic [7:0] SCG_OP_SANITIZE = 8'h84;
    localparam logic [7:0] SCG_OP_VS_MIN   = 8'hC0;

    // Fabrics subcommand types
    localparam logic [7:0] SCG_FC_PROP_SET = 8'h00;
    localparam logic [7:0] SCG_FC_CONNECT  = 8'h01;
    localparam logic [7:0] SCG_FC_PROP_GET = 8'h04;
    localparam logic [7:0] SCG_FC_AUTH_SND = 8'h05;
    localparam logic [7:0] SCG_FC_AUTH_RCV = 8'h06;

    // Log page identifiers
    localparam logic [7:0] SCG_LOG_ERROR   = 8'h01;
    localparam logic [7:0] SCG_LOG_SMART   = 8'h02;
    localparam logic [7:0] SCG_LOG_NS_CHG  = 8'h04;
    localparam logic [7:0] SCG_LOG_RESV    = 8'h80;
    localparam logic [7:0] SCG_LOG_SANIT   = 8'h81;

    // Sanitize action codes
    localparam logic [2:0] SCG_ACT_EXIT_FAIL = 3'h1;

    // Reset values
    localparam logic [7:0] SCG_RST_BYTE    = 8'h00;

    function automatic logic scg_is_vendor(input logic [7:0] code);
        return code >= SCG_OP_VS_MIN;
    endfunction

    function automatic logic scg_log_ok(input logic [7:0] id);
        return (id == SCG_LOG_ERROR) || (id == SCG_LOG_SMART) || (id == SCG_LOG_NS_CHG) ||
               (id == SCG_LOG_RESV) || (id == SCG_LOG_SANIT);
    endfunction

    function automatic logic scg_fabric_ok(input logic [7:0] fc);
        return (fc == SCG_FC_PROP_SET) || (fc == SCG_FC_CONNECT) || (fc == SCG_FC_PROP_GET) ||
               (fc == SCG_FC_AUTH_SND) || (fc == SCG_FC_AUTH_RCV) || scg_is_vendor(fc);
    endfunction

endpackage

// ### test/scg_exec_model.sv
// Execution engine model that takes dispatched commands promptly or with stalls
`timescale 1ns/1ps
`default_nettype none
module scg_exec_model (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic slow_i,
    output logic      ready_o
);
    integer seed = 32'h17EA3CED;
    // In slow mode the engine takes a command in about one cycle of four
    always @(posedge clk_i) begin
        ready_o <= srst_i || !slow_i || (($random(seed) & 3) == 0);
    end
endmodule
`default_nettype wire

// ### test/scg_gate_tb_top.sv
// Self-checking bench for the sanitize command gate
`timescale 1ns/1ps
`default_nettype none
module scg_gate_tb_top
    import scg_pkg::*;
;
    logic ref_clk_i, srst_i, cmd_valid_i, cmd_ready_o, cmd_admin_i, cmd_vs_user_data_i;
    logic [7:0] cmd_opcode_i, cmd_fctype_i, cmd_log_id_i, out_opcode_o, out_status_o, fail_action_mask_i;
    logic [2:0] cmd_san_action_i, san_cmd_action_i;
    logic out_valid_o, out_ready_i, out_admin_o, out_abort_o, out_lba_zero_o, slow_i;
    logic san_cmd_done_i, san_cmd_ok_i, san_op_done_i, san_op_ok_i, mgmt_allow_i, san_in_prog_o, san_failed_o;
    integer seed = 32'h17EA3CED;
    int err_total = 0;
    int n_tests = 0;
    scg_state_type st;
    logic [18:0] exp_q[$];
    logic [18:0] e;
    logic [7:0] adm_tab[10] = '{SCG_OP_DEL_SQ, SCG_OP_CRT_SQ, SCG_OP_DEL_CQ, SCG_OP_CRT_CQ, SCG_OP_IDENTIFY,
        SCG_OP_ABORT, SCG_OP_SET_FEAT, SCG_OP_GET_FEAT, SCG_OP_ASYNC_EV, SCG_OP_KEEP_ALV};
    logic [7:0] op_tab[16] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h0C, 8'h18,
        8'h1D, 8'h1E, 8'h7F, 8'h84, 8'hC3};
    logic [7:0] fc_tab[8] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'hC0, 8'hFF, 8'h02};
    logic [7:0] log_tab[8] = '{8'h01, 8'h02, 8'h04, 8'h80, 8'h81, 8'h00, 8'h03, 8'hFF};

    scg_gate i_scg_gate (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_admin_i(cmd_admin_i), .cmd_opcode_i(cmd_opcode_i),
        .cmd_fctype_i(cmd_fctype_i), .cmd_log_id_i(cmd_log_id_i), .cmd_san_action_i(cmd_san_action_i),
        .cmd_vs_user_data_i(cmd_vs_user_data_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
        .out_admin_o(out_admin_o), .out_opcode_o(out_opcode_o), .out_abort_o(out_abort_o),
        .out_status_o(out_status_o), .out_lba_zero_o(out_lba_zero_o), .san_cmd_done_i(san_cmd_done_i),
        .san_cmd_ok_i(san_cmd_ok_i), .san_cmd_action_i(san_cmd_action_i), .san_op_done_i(san_op_done_i),
        .san_op_ok_i(san_op_ok_i), .mgmt_allow_i(mgmt_allow_i), .fail_action_mask_i(fail_action_mask_i),
        .san_in_prog_o(san_in_prog_o), .san_failed_o(san_failed_o));
    scg_exec_model i_scg_exec_model (.clk_i(ref_clk_i), .srst_i(srst_i), .slow_i(slow_i), .ready_o(out_ready_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic in8(input logic [7:0] v, input logic [7:0] t[10], input int n);
        for (int i = 0; i < n; i++) if (t[i] == v) return 1'b1;
        return 1'b0;
    endfunction

    // Expected abort, status and zero-address flag of one command
    function automatic logic [9:0] cls(input scg_state_type s, input logic adm, input logic [7:0] op,
                                       input logic [7:0] fc, input logic [7:0] lg, input logic [2:0] act,
                                       input logic vs, input logic mg, input logic [7:0] mask);
        logic ok;
        logic [7:0] sc;
        sc = (s == SCG_ST_RUN) ? SCG_SC_IN_PROG : SCG_SC_FAILED;
        if (op == SCG_OP_FABRICS) ok = fc == SCG_FC_PROP_SET || fc == SCG_FC_CONNECT || fc == SCG_FC_PROP_GET ||
            fc == SCG_FC_AUTH_SND || fc == SCG_FC_AUTH_RCV || (fc >= 8'hC0 && !vs);
        else if (!adm) ok = 1'b0;
        else if (op == SCG_OP_GET_LOG) ok = lg == SCG_LOG_ERROR || lg == SCG_LOG_SMART || lg == SCG_LOG_NS_CHG ||
            lg == SCG_LOG_RESV || lg == SCG_LOG_SANIT;
        else if (in8(op, adm_tab, 10)) ok = 1'b1;
        else if (op == SCG_OP_MGMT_SND || op == SCG_OP_MGMT_RCV) ok = mg;
        else if (op >= 8'hC0) ok = !vs;
        else ok = (op == SCG_OP_SANITIZE) && (s == SCG_ST_FAILED) && mask[act];
        if (s == SCG_ST_IDLE) return {1'b0, SCG_SC_SUCCESS, 1'b0};
        return {!ok, ok ? SCG_SC_SUCCESS : sc, ok && adm && op == SCG_OP_GET_LOG && lg == SCG_LOG_ERROR};
    endfunction

    task automatic chk(input logic c, input string m);
        n_tests++;
        if (c !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Reference state and scoreboard, all sampled on the edge the design samples
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            exp_q.delete();
            st <= SCG_ST_IDLE;
        end else begin
            chk(san_in_prog_o === (st == SCG_ST_RUN) && san_failed_o === (st == SCG_ST_FAILED),
                "state");
            chk(cmd_ready_o === (!out_valid_o || out_ready_i), "ready");
            if (out_valid_o === 1'b1 && out_ready_i) begin
                e = (exp_q.size() > 0) ? exp_q.pop_front() : 19'h7FFFF;
                chk({out_abort_o, out_status_o, out_lba_zero_o, out_admin_o, out_opcode_o} === e,
                    "verdict");
            end
            if (cmd_valid_i && cmd_ready_o) exp_q.push_back({cls(st, cmd_admin_i, cmd_opcode_i, cmd_fctype_i,
                cmd_log_id_i, cmd_san_action_i, cmd_vs_user_data_i, mgmt_allow_i, fail_action_mask_i),
                cmd_admin_i, cmd_opcode_i});
            if (st == SCG_ST_IDLE && san_cmd_done_i && san_cmd_ok_i && san_cmd_action_i != SCG_ACT_EXIT_FAIL)
                st <= SCG_ST_RUN;
            if (st == SCG_ST_RUN && san_op_done_i) st <= san_op_ok_i ? SCG_ST_IDLE : SCG_ST_FAILED;
            if (st == SCG_ST_FAILED && san_cmd_done_i && san_cmd_ok_i)
                st <= (san_cmd_action_i == SCG_ACT_EXIT_FAIL) ? SCG_ST_IDLE : SCG_ST_RUN;
        end
    end

    task automatic cyc(input logic ec, input logic eo, input logic ok, input logic [2:0] act);
        logic [31:0] r, r2;
        r = $random(seed);
        r2 = $random(seed);
        @(posedge ref_clk_i);
        if (!cmd_valid_i || cmd_ready_o) begin
            cmd_valid_i <= r[1:0] != 2'h0;
            cmd_opcode_i <= r[4] ? op_tab[r[3:0]] : r[15:8];
            cmd_fctype_i <= r[5] ? fc_tab[r[18:16]] : r[31:24];
            cmd_log_id_i <= r[6] ? log_tab[r[21:19]] : r2[7:0];
            cmd_san_action_i <= r2[10:8];
            cmd_vs_user_data_i <= r2[11];
            cmd_admin_i <= r[7] | r2[12];
        end
        san_cmd_done_i <= ec;
        san_op_done_i <= eo;
        san_cmd_ok_i <= ok;
        san_op_ok_i <= ok;
        san_cmd_action_i <= act;
    endtask

    task automatic goto(input scg_state_type t);
        logic s;
        for (int i = 0; i < 6 && st != t; i++) begin
            s = (t == SCG_ST_RUN) || (t == SCG_ST_FAILED && st != SCG_ST_RUN) || (t == SCG_ST_IDLE && st == SCG_ST_FAILED);
            cyc(s, !s, s || t == SCG_ST_IDLE, (t == SCG_ST_IDLE) ? SCG_ACT_EXIT_FAIL : 3'h2);
            cyc(1'b0, 1'b0, 1'b0, 3'h0);
            cyc(1'b0, 1'b0, 1'b0, 3'h0);
        end
    endtask

    initial begin
        logic [31:0] r3;
        {cmd_valid_i, cmd_admin_i, cmd_vs_user_data_i, cmd_opcode_i, cmd_fctype_i, cmd_log_id_i} = '0;
        {cmd_san_action_i, san_cmd_action_i, san_cmd_done_i, san_cmd_ok_i, san_op_done_i, san_op_ok_i} = '0;
        {mgmt_allow_i, fail_action_mask_i, slow_i} = '0;
        srst_i = 1'b1;
        repeat (20) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        #1;
        chk(out_valid_o === 1'b0 && out_status_o === 8'h00 && san_in_prog_o === 1'b0 && cmd_ready_o === 1'b1,
            "reset");
        for (int p = 0; p < 4; p++) begin
            mgmt_allow_i <= p[0];
            slow_i <= p[1];
            fail_action_mask_i <= $random(seed);
            for (int s = 0; s < 3; s++) begin
                goto(scg_state_type'(s));
                repeat (400) begin
                    r3 = $random(seed);
                    cyc(r3[6:0] == 7'h00, r3[13:7] == 7'h01, r3[14], r3[17:15]);
                end
            end
        end
        @(posedge ref_clk_i);
        while (cmd_valid_i && !cmd_ready_o) @(posedge ref_clk_i);
        cmd_valid_i <= 1'b0;
        san_cmd_done_i <= 1'b0;
        san_op_done_i <= 1'b0;
        repeat (60) @(posedge ref_clk_i);
        chk(exp_q.size() == 0, "commands lost");
        finish_test();
    end

    initial begin
        #100000;
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
